// *** design/sptl_fifo.v ***
// sptl_fifo.v: synchronous fifo with valid/ready on both sides.
// Assumes one clock; full and empty are exact, depth is a power of two.
`timescale 1ns/10ps
module sptl_fifo #(
  parameter WIDTH = 33,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  // clock and reset
  input  wire             CLK,
  input  wire             NRST,
  // fill side
  input  wire             IN_VALID,
  output wire             IN_READY,
  input  wire [WIDTH-1:0] IN_DATA,
  // drain side
  output wire             OUT_VALID,
  input  wire             OUT_READY,
  output wire [WIDTH-1:0] OUT_DATA
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr_r;
  reg [AW:0]      rd_ptr_r;
  wire            full;
  wire            empty;
  wire            push;
  wire            pop;

  assign empty     = (wr_ptr_r == rd_ptr_r);
  assign full      = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign IN_READY  = ~full;
  assign OUT_VALID = ~empty;
  assign OUT_DATA  = mem[rd_ptr_r[AW-1:0]];
  assign push      = IN_VALID & ~full;
  assign pop       = OUT_READY & ~empty;

  always @(posedge CLK) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= IN_DATA;
    end
  end

  always @(posedge CLK) begin
    if (!NRST) begin
      wr_ptr_r <= {(AW+1){1'b0}};
      rd_ptr_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule

// *** design/sptl_loopback_test.v ***
// sptl_loopback_test.v: test-mode logic of the serial audio port: pattern
// transmit, receive-to-transmit loopback through a frame buffer, pin loopback.
// Assumes bit clock and frame sync come from the far party and are much slower
// than CLK; normal transmit data and config bits arrive on CLK from port logic.
`timescale 1ns/10ps
`include "sptl_map.vh"

// Operation
// - two read/write enables: loopback bit1, pattern bit0
// - loopback sends selected receive pin on both outputs
// - loopback without buffer capture sends default pattern
// - capture cleared during loopback repeats last frame
// - loopback ignores output enables and interleave
// - pattern mode sends pattern everywhere, ignores enables
// - loopback overrides pattern mode
// - pin loopback routes outputs to inputs, overrides loopback, capture and select, not pattern
// - capture bit stores selected input, ignores input config
// - select bit chooses input pin a or b
module sptl_loopback_test #(
  parameter FRAME_WORDS = 2,
  parameter WIDX        = 1,
  parameter PATTERN     = `SPTL_DEFAULT_PATTERN,
  parameter FIFO_DEPTH  = `SPTL_FIFO_DEPTH,
  parameter FIFO_AW     = 3
) (
  // clock and reset
  input  wire       CLK,
  input  wire       NRST,
  // register port
  input  wire       REG_WR,
  input  wire [7:0] REG_ADDR,
  input  wire [7:0] REG_WDATA,
  output reg  [7:0] REG_RDATA,
  // serial pins from the far party
  input  wire       BIT_CLK,
  input  wire       FRAME_SYNC,
  input  wire       SERIAL_IN_PIN_A,
  input  wire       SERIAL_IN_PIN_B,
  // serial output pins
  output reg        SERIAL_OUT_PIN_A,
  output reg        SERIAL_OUT_PIN_A_OE,
  output reg        SERIAL_OUT_PIN_B,
  output reg        SERIAL_OUT_PIN_B_OE,
  // normal transmit path and its configuration
  input  wire       NORM_TX_A,
  input  wire       NORM_TX_B,
  input  wire       OUT_PIN_A_ENABLE,
  input  wire       OUT_PIN_B_ENABLE,
  input  wire       OUT_PIN_INTERLEAVE,
  // normal receive configuration
  input  wire       IN_PIN_A_ENABLE,
  input  wire       IN_PIN_B_ENABLE,
  input  wire       IN_PIN_INTERLEAVE,
  // towards the normal receive path, and output interleave to the transmit path
  output reg        RX_DATA_A,
  output reg        RX_DATA_B,
  output reg        RX_BIT_STROBE,
  output reg        IN_PIN_A_ENABLE_EFF,
  output reg        IN_PIN_B_ENABLE_EFF,
  output reg        IN_PIN_INTERLEAVE_EFF,
  output reg        OUT_PIN_INTERLEAVE_EFF,
  // capture status
  output reg        CAPTURE_OVERRUN
);
  localparam FRAME_BITS = FRAME_WORDS * `SPTL_WORD_BITS;
  localparam PW         = WIDX + `SPTL_WORD_POS_BITS;
  localparam FW         = WIDX + `SPTL_WORD_BITS;

  // transmit source modes, one-hot
  localparam SRC_NORMAL  = 3'b001;
  localparam SRC_PATTERN = 3'b010;
  localparam SRC_BUFFER  = 3'b100;

  reg [7:0]  test_ctrl_r;
  reg [31:0] frame_mem [0:FRAME_WORDS-1];
  wire bclk_s;
  wire fsync_s;
  wire pin_a_s;
  wire pin_b_s;
  reg  bclk_d_r;
  reg  fsync_d_r;
  wire bclk_rise;
  wire bclk_fall;
  wire fsync_rise;
  wire pattern_en;
  wire loopback_en;
  wire capture_en;
  wire src_b_sel;
  wire pin_lb_en;
  reg  [2:0] src_r;
  reg  [2:0] src_nxt;
  reg        use_buf_r;
  reg        use_buf_nxt;
  reg  [PW-1:0] tx_pos_r;
  integer       k;
  reg  [31:0]   rx_shift_r;
  reg           push_r;
  reg  [FW-1:0] push_data_r;
  wire          fifo_in_ready;
  wire          fifo_out_valid;
  wire [FW-1:0] fifo_out_data;
  wire          drain_ready;
  wire          drain;
  wire          tx_bit_pat;
  wire          tx_bit_buf;
  wire [31:0]   tx_word;
  reg           tx_a_nxt;
  reg           tx_b_nxt;
  reg           oe_a_nxt;
  reg           oe_b_nxt;
  wire          rx_a_eff;
  wire          rx_b_eff;
  wire          rx_sel_bit;
  wire [31:0]   rx_word_nxt;

  // pin inputs cross into CLK through two flops each
  sptl_sync #(.INIT(1'b1)) u_sync_bclk (.CLK(CLK), .NRST(NRST), .D(BIT_CLK), .Q(bclk_s));
  sptl_sync u_sync_fsync (.CLK(CLK), .NRST(NRST), .D(FRAME_SYNC),      .Q(fsync_s));
  sptl_sync u_sync_pin_a (.CLK(CLK), .NRST(NRST), .D(SERIAL_IN_PIN_A), .Q(pin_a_s));
  sptl_sync u_sync_pin_b (.CLK(CLK), .NRST(NRST), .D(SERIAL_IN_PIN_B), .Q(pin_b_s));

  // edge detectors reset to the pins' idle levels, so reset shows no edge
  always @(posedge CLK) begin
    if (!NRST) begin
      bclk_d_r      <= 1'b1;
      fsync_d_r     <= 1'b0;
      RX_DATA_A     <= 1'b0;
      RX_DATA_B     <= 1'b0;
      RX_BIT_STROBE <= 1'b0;
    end else begin
      bclk_d_r      <= bclk_s;
      fsync_d_r     <= fsync_s;
      RX_DATA_A     <= rx_a_eff;
      RX_DATA_B     <= rx_b_eff;
      RX_BIT_STROBE <= bclk_rise;
    end
  end

  assign bclk_rise  = bclk_s & ~bclk_d_r;
  assign bclk_fall  = ~bclk_s & bclk_d_r;
  assign fsync_rise = fsync_s & ~fsync_d_r;

  // test-control register; reserved bits and other addresses read zero
  always @(posedge CLK) begin
    if (!NRST) begin
      test_ctrl_r <= `SPTL_TEST_CTRL_RESET;
      REG_RDATA   <= 8'h00;
    end else begin
      if (REG_WR && REG_ADDR == `SPTL_TEST_CTRL_ADDR) begin
        test_ctrl_r <= REG_WDATA & `SPTL_TEST_CTRL_MASK;
      end
      REG_RDATA <= (REG_ADDR == `SPTL_TEST_CTRL_ADDR) ? test_ctrl_r : 8'h00;
    end
  end

  // pin loopback masks the receive-side test bits
  assign pin_lb_en   = test_ctrl_r[`SPTL_PIN_LOOPBACK_BIT];
  assign loopback_en = test_ctrl_r[`SPTL_LOOPBACK_TX_BIT] & ~pin_lb_en;
  assign capture_en  = test_ctrl_r[`SPTL_RX_TO_BUF_BIT] & ~pin_lb_en;
  assign src_b_sel   = test_ctrl_r[`SPTL_SRC_SELECT_BIT] & ~pin_lb_en;
  assign pattern_en  = test_ctrl_r[`SPTL_PATTERN_TX_BIT];

  // buffer becomes the source only once capture ran under loopback;
  // dropping capture afterwards keeps the buffer, so the last frame repeats
  always @* begin
    use_buf_nxt = use_buf_r;
    if (!loopback_en) begin
      use_buf_nxt = 1'b0;
    end else if (capture_en) begin
      use_buf_nxt = 1'b1;
    end
  end

  always @* begin
    if (loopback_en && use_buf_nxt) begin
      src_nxt = SRC_BUFFER;
    end else if (loopback_en) begin
      src_nxt = SRC_PATTERN;
    end else if (pattern_en) begin
      src_nxt = SRC_PATTERN;
    end else begin
      src_nxt = SRC_NORMAL;
    end
  end

  always @(posedge CLK) begin
    if (!NRST) begin
      use_buf_r <= 1'b0;
      src_r     <= SRC_NORMAL;
    end else begin
      use_buf_r <= use_buf_nxt;
      src_r     <= src_nxt;
    end
  end

  // receive data seen by logic: pin loopback feeds each output back
  assign rx_a_eff   = pin_lb_en ? SERIAL_OUT_PIN_A : pin_a_s;
  assign rx_b_eff   = pin_lb_en ? SERIAL_OUT_PIN_B : pin_b_s;
  assign rx_sel_bit = src_b_sel ? rx_b_eff : rx_a_eff;

  // capture shares the transmit position; pushes each completed slot
  assign rx_word_nxt = {rx_shift_r[30:0], rx_sel_bit};

  always @(posedge CLK) begin
    if (!NRST) begin
      rx_shift_r  <= 32'h0000_0000;
      push_r      <= 1'b0;
      push_data_r <= {FW{1'b0}};
    end else begin
      push_r <= 1'b0;
      if (bclk_rise && !fsync_rise) begin
        rx_shift_r <= rx_word_nxt;
        // input enables and interleave play no part in capture
        if (capture_en && tx_pos_r[`SPTL_WORD_POS_BITS-1:0] == 5'h1f) begin
          push_r      <= 1'b1;
          push_data_r <= {tx_pos_r[PW-1:`SPTL_WORD_POS_BITS], rx_word_nxt};
        end
      end
    end
  end

  // a full fifo loses the slot; flagged until reset or capture off
  always @(posedge CLK) begin
    if (!NRST) begin
      CAPTURE_OVERRUN <= 1'b0;
    end else if (push_r && !fifo_in_ready) begin
      CAPTURE_OVERRUN <= 1'b1;
    end else if (!capture_en) begin
      CAPTURE_OVERRUN <= 1'b0;
    end
  end

  sptl_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH),
    .AW   (FIFO_AW)
  ) u_fifo (
    .CLK      (CLK),
    .NRST     (NRST),
    .IN_VALID (push_r),
    .IN_READY (fifo_in_ready),
    .IN_DATA  (push_data_r),
    .OUT_VALID(fifo_out_valid),
    .OUT_READY(drain_ready),
    .OUT_DATA (fifo_out_data)
  );

  // drain stalls while the transmitter reads the same slot, so a slot
  // never changes in the middle of being sent
  assign drain_ready = (fifo_out_data[FW-1:`SPTL_WORD_BITS] != tx_pos_r[PW-1:`SPTL_WORD_POS_BITS])
                       || (src_r != SRC_BUFFER);
  assign drain       = drain_ready & fifo_out_valid;

  always @(posedge CLK) begin
    if (!NRST) begin
      for (k = 0; k < FRAME_WORDS; k = k + 1) begin
        frame_mem[k] <= 32'h0000_0000;
      end
    end else if (drain) begin
      frame_mem[fifo_out_data[FW-1:`SPTL_WORD_BITS]] <= fifo_out_data[31:0];
    end
  end

  // transmit position follows frame sync and bit clock
  always @(posedge CLK) begin
    if (!NRST) begin
      tx_pos_r <= {PW{1'b0}};
    end else if (fsync_rise) begin
      tx_pos_r <= {PW{1'b0}};
    end else if (bclk_rise) begin
      if (tx_pos_r == FRAME_BITS - 1) begin
        tx_pos_r <= {PW{1'b0}};
      end else begin
        tx_pos_r <= tx_pos_r + 1'b1;
      end
    end
  end

  // msb first in every slot; same pattern in every channel
  assign tx_bit_pat = PATTERN[5'h1f - tx_pos_r[`SPTL_WORD_POS_BITS-1:0]];
  assign tx_word    = frame_mem[tx_pos_r[PW-1:`SPTL_WORD_POS_BITS]];
  assign tx_bit_buf = tx_word[5'h1f - tx_pos_r[`SPTL_WORD_POS_BITS-1:0]];

  always @* begin
    tx_a_nxt = SERIAL_OUT_PIN_A;
    tx_b_nxt = SERIAL_OUT_PIN_B;
    oe_a_nxt = 1'b1;
    oe_b_nxt = 1'b1;
    case (src_r)
      SRC_NORMAL: begin
        tx_a_nxt = NORM_TX_A;
        tx_b_nxt = NORM_TX_B;
        oe_a_nxt = OUT_PIN_A_ENABLE;
        oe_b_nxt = OUT_PIN_B_ENABLE;
      end
      SRC_PATTERN, SRC_BUFFER: begin
        // pin b copies pin a, so both agree even before the first bit
        tx_b_nxt = SERIAL_OUT_PIN_A;
        if (bclk_fall) begin
          tx_a_nxt = (src_r == SRC_BUFFER) ? tx_bit_buf : tx_bit_pat;
          tx_b_nxt = tx_a_nxt;
        end
      end
      default: begin
        tx_a_nxt = 1'b0;
        tx_b_nxt = 1'b0;
      end
    endcase
  end

  // test sources drive both pins regardless of the output enables;
  // the normal paths see the configuration that a test mode overrides
  always @(posedge CLK) begin
    if (!NRST) begin
      SERIAL_OUT_PIN_A       <= 1'b0;
      SERIAL_OUT_PIN_B       <= 1'b0;
      SERIAL_OUT_PIN_A_OE    <= 1'b0;
      SERIAL_OUT_PIN_B_OE    <= 1'b0;
      OUT_PIN_INTERLEAVE_EFF <= 1'b0;
      IN_PIN_A_ENABLE_EFF    <= 1'b0;
      IN_PIN_B_ENABLE_EFF    <= 1'b0;
      IN_PIN_INTERLEAVE_EFF  <= 1'b0;
    end else begin
      SERIAL_OUT_PIN_A       <= tx_a_nxt;
      SERIAL_OUT_PIN_B       <= tx_b_nxt;
      SERIAL_OUT_PIN_A_OE    <= oe_a_nxt;
      SERIAL_OUT_PIN_B_OE    <= oe_b_nxt;
      OUT_PIN_INTERLEAVE_EFF <= OUT_PIN_INTERLEAVE & (src_nxt == SRC_NORMAL);
      IN_PIN_A_ENABLE_EFF    <= IN_PIN_A_ENABLE | capture_en;
      IN_PIN_B_ENABLE_EFF    <= IN_PIN_B_ENABLE | capture_en;
      IN_PIN_INTERLEAVE_EFF  <= IN_PIN_INTERLEAVE & ~capture_en;
    end
  end
endmodule

// *** design/sptl_map.vh ***
// sptl_map.vh: register address, field positions and reset values of the
// serial port test logic. Definitions only; included by the design files.
`ifndef SPTL_MAP_VH
`define SPTL_MAP_VH

// test-control register address on the register port
`define SPTL_TEST_CTRL_ADDR   8'h53
`define SPTL_TEST_CTRL_RESET  8'h00
`define SPTL_TEST_CTRL_MASK   8'h1f

// field positions in the test-control register
`define SPTL_PATTERN_TX_BIT   0
`define SPTL_LOOPBACK_TX_BIT  1
`define SPTL_RX_TO_BUF_BIT    2
`define SPTL_SRC_SELECT_BIT   3
`define SPTL_PIN_LOOPBACK_BIT 4

// capture word size: one channel slot
`define SPTL_WORD_BITS        32
`define SPTL_WORD_POS_BITS    5

// default test pattern repeated in every channel
`define SPTL_DEFAULT_PATTERN  32'ha5c3_0f96

// synchroniser depth and capture fifo depth
`define SPTL_SYNC_STAGES      2
`define SPTL_FIFO_DEPTH       8

`endif

// *** design/sptl_sync.v ***
// sptl_sync.v: two-flop synchroniser for one level from outside CLK's domain.
// Assumes the level is slow against CLK; the first flop feeds only the second.
`timescale 1ns/10ps
module sptl_sync #(
  parameter [0:0] INIT = 1'b0
) (
  // clock and reset
  input  wire CLK,
  input  wire NRST,
  // level in and out
  input  wire D,
  output wire Q
);
  reg meta_r;
  reg sync_r;

  always @(posedge CLK) begin
    if (!NRST) begin
      meta_r <= INIT;
      sync_r <= INIT;
    end else begin
      meta_r <= D;
      sync_r <= meta_r;
    end
  end

  assign Q = sync_r;
endmodule

// *** test/sptl_far_end.sv ***
// far party on the serial pins: makes bit clock and frame sync, drives data
// assumes 160 ns bits; clock stands high between frames
`timescale 1ns/10ps
module sptl_far_end (
  // towards the block
  output reg  bit_clk,
  output reg  frame_sync,
  output reg  pin_a,
  output reg  pin_b,
  // from the block
  input  wire out_a,
  input  wire out_b
);
  reg   [63:0] got_a;
  reg   [63:0] got_b;
  event        done;
  initial begin
    bit_clk = 1'b1;
    frame_sync = 1'b0;
    pin_a = 1'b0;
    pin_b = 1'b1;
  end
  // data changes on the fall, outputs read on the rise
  task frame(input [63:0] da, input [63:0] db);
    integer i;
    begin
      frame_sync = 1'b1;
      #41.3;
      for (i = 0; i < 64; i = i + 1) begin
        bit_clk = 1'b0;
        frame_sync = (i == 0);
        pin_a = da[63-i];
        pin_b = db[63-i];
        #80 bit_clk = 1'b1;
        got_a = {got_a[62:0], out_a};
        got_b = {got_b[62:0], out_b};
        #80;
      end
      // flip idle data so a stale bit never looks valid
      pin_a = ~pin_a;
      pin_b = ~pin_b;
      -> done;
    end
  endtask
endmodule

// *** test/sptl_loopback_test_bench.sv ***
// bench: registers, pattern, loopback and capture modes of the test logic
// assumes the far-end model on the pins and the checker bound in its file
`timescale 1ns/10ps
`include "sptl_map.vh"
`define CHK(n, e, g) begin num_checks = num_checks + 1; if ((g) !== (e)) begin errors = errors + 1; \
  $display("wrong value %0s exp %h got %h", n, e, g); end end
module sptl_loopback_test_bench;
  localparam [31:0] PAT = 32'h1e2d_b487;
  localparam [63:0] PAT2 = {PAT, PAT};
  localparam [7:0]  TA = `SPTL_TEST_CTRL_ADDR;
  reg         clk;
  reg         nrst;
  reg         wr_en;
  reg  [7:0]  addr;
  reg  [7:0]  wdata;
  reg  [7:0]  cfg;
  reg         chk_rx;
  wire [7:0]  rdata;
  wire        bclk, fs, in_a, in_b, out_a, out_b, rx_a, rx_b, stb;
  integer     errors;
  integer     num_checks;
  reg  [64:0] exp_q[$];
  reg  [64:0] e;
  reg  [63:0] w;
  sptl_loopback_test #(.PATTERN(PAT)) i_dut (.CLK(clk), .NRST(nrst), .REG_WR(wr_en), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .BIT_CLK(bclk), .FRAME_SYNC(fs), .SERIAL_IN_PIN_A(in_a),
    .SERIAL_IN_PIN_B(in_b), .SERIAL_OUT_PIN_A(out_a), .SERIAL_OUT_PIN_A_OE(), .SERIAL_OUT_PIN_B(out_b),
    .SERIAL_OUT_PIN_B_OE(), .NORM_TX_A(cfg[0]), .NORM_TX_B(cfg[1]), .OUT_PIN_A_ENABLE(cfg[2]),
    .OUT_PIN_B_ENABLE(cfg[3]), .OUT_PIN_INTERLEAVE(cfg[4]), .IN_PIN_A_ENABLE(cfg[5]),
    .IN_PIN_B_ENABLE(cfg[6]), .IN_PIN_INTERLEAVE(cfg[7]), .RX_DATA_A(rx_a), .RX_DATA_B(rx_b),
    .RX_BIT_STROBE(stb), .IN_PIN_A_ENABLE_EFF(), .IN_PIN_B_ENABLE_EFF(), .IN_PIN_INTERLEAVE_EFF(),
    .OUT_PIN_INTERLEAVE_EFF(), .CAPTURE_OVERRUN());
  sptl_far_end i_far (.bit_clk(bclk), .frame_sync(fs), .pin_a(in_a), .pin_b(in_b), .out_a(out_a), .out_b(out_b));
  always #2.5 clk = ~clk;
  always @(negedge clk) cfg <= $urandom;
  task stop_test;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  function automatic [63:0] rnd();
    rnd = {$urandom, $urandom};
  endfunction
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk);
      wr_en = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr_en = 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] x);
    begin
      @(negedge clk);
      addr = a;
      repeat (2) @(negedge clk);
      `CHK("register", x, rdata)
    end
  endtask
  // n frames; only those from index keep on are compared
  task run(input integer n, input [63:0] da, input [63:0] db, input [63:0] x, input integer keep);
    integer i;
    begin
      for (i = 0; i < n; i = i + 1) begin
        exp_q.push_back({i >= keep, x});
        i_far.frame(da, db);
      end
    end
  endtask
  always @(i_far.done) begin
    e = exp_q.pop_front();
    if (e[64]) begin
      `CHK("pin a frame", e[63:0], i_far.got_a)
      `CHK("pin b frame", e[63:0], i_far.got_b)
    end
  end
  always @(negedge clk) begin
    if (chk_rx && stb) begin
      `CHK("rx a", out_a, rx_a)
      `CHK("rx b", out_b, rx_b)
    end
  end
  initial begin
    #400000;
    errors = errors + 1;
    stop_test;
  end
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    wr_en = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    chk_rx = 1'b0;
    errors = 0;
    num_checks = 0;
    w = $urandom(73);
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    rd(TA, 8'h00);
    wr(TA, 8'hff);
    rd(TA, 8'h1f);
    wr(8'h54, 8'h00);
    rd(TA, 8'h1f);
    rd(8'h54, 8'h00);
    $display("test registers done");
    wr(TA, 8'h01);
    run(2, rnd(), rnd(), PAT2, 0);
    $display("test pattern done");
    chk_rx = 1'b1;
    wr(TA, 8'h1f);
    run(2, rnd(), rnd(), PAT2, 0);
    chk_rx = 1'b0;
    $display("test pin loopback done");
    wr(TA, 8'h02);
    run(2, rnd(), rnd(), PAT2, 0);
    w = rnd();
    wr(TA, 8'h07);
    run(3, w, ~w, w, 2);
    wr(TA, 8'h03);
    run(2, rnd(), rnd(), w, 0);
    $display("test loopback pin a done");
    wr(TA, 8'h00);
    w = rnd();
    wr(TA, 8'h0e);
    run(3, rnd(), w, w, 2);
    $display("test loopback pin b done");
    @(negedge clk);
    nrst = 1'b0;
    repeat (6) @(negedge clk);
    nrst = 1'b1;
    rd(TA, 8'h00);
    run(1, rnd(), rnd(), 64'h0, 1);
    $display("test normal path done");
    repeat (10) @(negedge clk);
    stop_test;
  end
endmodule

// *** test/sptl_loopback_test_chk.sv ***
// checker: port assertions of the serial port test logic
// assumes the block's own port names; bound to it at the foot
`timescale 1ns/10ps
`include "sptl_map.vh"
module sptl_loopback_test_chk (
  // clock, reset and register port
  input wire       CLK,
  input wire       NRST,
  input wire       REG_WR,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire [7:0] REG_RDATA,
  // normal transmit and receive configuration inputs
  input wire       NORM_TX_A,
  input wire       NORM_TX_B,
  input wire       IN_PIN_A_ENABLE,
  input wire       IN_PIN_B_ENABLE,
  input wire       IN_PIN_INTERLEAVE,
  input wire       OUT_PIN_A_ENABLE,
  input wire       OUT_PIN_B_ENABLE,
  input wire       OUT_PIN_INTERLEAVE,
  // outputs
  input wire       SERIAL_OUT_PIN_A,
  input wire       SERIAL_OUT_PIN_B,
  input wire       SERIAL_OUT_PIN_A_OE,
  input wire       SERIAL_OUT_PIN_B_OE,
  input wire       RX_BIT_STROBE,
  input wire       IN_PIN_A_ENABLE_EFF,
  input wire       IN_PIN_B_ENABLE_EFF,
  input wire       IN_PIN_INTERLEAVE_EFF,
  input wire       OUT_PIN_INTERLEAVE_EFF,
  input wire       CAPTURE_OVERRUN
);
  reg  [4:0] ctl_r;
  reg  [3:0] tm_r;
  reg  [3:0] cp_r;
  // pin loopback masks the loopback and capture bits
  wire       tm_nxt = ctl_r[0] | (ctl_r[1] & ~ctl_r[4]);
  wire       cp_nxt = ctl_r[2] & ~ctl_r[4];
  // a mode counts only after four settled cycles
  wire       tst    = &tm_r;
  wire       nrm    = ~|tm_r;
  wire       cap    = &cp_r;
  wire       ncap   = ~|cp_r;
  always @(posedge CLK) begin
    if (!NRST) begin
      ctl_r <= 5'h00;
      tm_r  <= 4'h8;
      cp_r  <= 4'h8;
    end else begin
      if (REG_WR && REG_ADDR == `SPTL_TEST_CTRL_ADDR) ctl_r <= REG_WDATA[4:0];
      tm_r <= {tm_r[2:0], tm_nxt};
      cp_r <= {cp_r[2:0], cp_nxt};
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  a_read_back: assert property ($past(REG_ADDR) == `SPTL_TEST_CTRL_ADDR |-> REG_RDATA == {3'h0, $past(ctl_r)})
    else $error("register read value wrong");
  a_unmapped_zero: assert property ($past(REG_ADDR) != `SPTL_TEST_CTRL_ADDR |-> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_norm_pass: assert property (nrm |-> SERIAL_OUT_PIN_A == $past(NORM_TX_A) &&
    SERIAL_OUT_PIN_B == $past(NORM_TX_B) &&
    SERIAL_OUT_PIN_A_OE == $past(OUT_PIN_A_ENABLE) && SERIAL_OUT_PIN_B_OE == $past(OUT_PIN_B_ENABLE))
    else $error("normal path not passed");
  a_test_drive: assert property (tst |-> SERIAL_OUT_PIN_A_OE && SERIAL_OUT_PIN_B_OE)
    else $error("test mode output not driven");
  a_pins_same: assert property (tst |-> SERIAL_OUT_PIN_A == SERIAL_OUT_PIN_B)
    else $error("test mode pins differ");
  a_bit_hold: assert property (tst && $changed(SERIAL_OUT_PIN_A) |=> $stable(SERIAL_OUT_PIN_A) [*8])
    else $error("output bit changed mid bit");
  a_tx_ilv_off: assert property (tst |-> !OUT_PIN_INTERLEAVE_EFF)
    else $error("interleave not forced off");
  a_tx_ilv_pass: assert property (nrm && ncap |-> OUT_PIN_INTERLEAVE_EFF == $past(OUT_PIN_INTERLEAVE))
    else $error("interleave not passed");
  a_capture_cfg: assert property (cap |-> IN_PIN_A_ENABLE_EFF && IN_PIN_B_ENABLE_EFF && !IN_PIN_INTERLEAVE_EFF)
    else $error("capture config not forced");
  a_rx_cfg_pass: assert property (ncap |-> IN_PIN_A_ENABLE_EFF == $past(IN_PIN_A_ENABLE) &&
    IN_PIN_B_ENABLE_EFF == $past(IN_PIN_B_ENABLE) && IN_PIN_INTERLEAVE_EFF == $past(IN_PIN_INTERLEAVE))
    else $error("input config not passed");
  a_strobe_pulse: assert property (RX_BIT_STROBE |=> !RX_BIT_STROBE [*8])
    else $error("bit strobe too long");
  a_overrun_clear: assert property (ncap |-> !CAPTURE_OVERRUN)
    else $error("overrun stuck without capture");
  c_test: cover property (tst && $changed(SERIAL_OUT_PIN_A));
  c_capture: cover property (cap && RX_BIT_STROBE);
  c_write: cover property (REG_WR && REG_ADDR == `SPTL_TEST_CTRL_ADDR);
endmodule

bind sptl_loopback_test sptl_loopback_test_chk i_chk (.CLK(CLK), .NRST(NRST), .REG_WR(REG_WR),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .NORM_TX_A(NORM_TX_A),
  .NORM_TX_B(NORM_TX_B), .IN_PIN_A_ENABLE(IN_PIN_A_ENABLE), .IN_PIN_B_ENABLE(IN_PIN_B_ENABLE),
  .IN_PIN_INTERLEAVE(IN_PIN_INTERLEAVE), .IN_PIN_B_ENABLE_EFF(IN_PIN_B_ENABLE_EFF),
  .OUT_PIN_A_ENABLE(OUT_PIN_A_ENABLE), .OUT_PIN_B_ENABLE(OUT_PIN_B_ENABLE), .OUT_PIN_INTERLEAVE(OUT_PIN_INTERLEAVE),
  .SERIAL_OUT_PIN_A(SERIAL_OUT_PIN_A), .SERIAL_OUT_PIN_B(SERIAL_OUT_PIN_B),
  .SERIAL_OUT_PIN_A_OE(SERIAL_OUT_PIN_A_OE), .SERIAL_OUT_PIN_B_OE(SERIAL_OUT_PIN_B_OE),
  .RX_BIT_STROBE(RX_BIT_STROBE), .IN_PIN_A_ENABLE_EFF(IN_PIN_A_ENABLE_EFF),
  .IN_PIN_INTERLEAVE_EFF(IN_PIN_INTERLEAVE_EFF), .OUT_PIN_INTERLEAVE_EFF(OUT_PIN_INTERLEAVE_EFF),
  .CAPTURE_OVERRUN(CAPTURE_OVERRUN));
